// File: core/uart_rx_fe_pkg.sv
// Constants and types shared by the receiver front end.
package uart_rx_fe_pkg;

	// ********************************************
	// Register map
	// ********************************************
	localparam logic [1:0] ADDR_CONTROL = 2'h0;
	localparam logic [1:0] ADDR_STATUS = 2'h1;
	localparam logic [1:0] ADDR_DATA = 2'h2;

	localparam int CTRL_RECEIVE_ON_BIT = 0;
	localparam int CTRL_FRAME_LEN_BIT = 1;
	localparam int STAT_RECEIVE_FULL_BIT = 0;
	localparam int STAT_NOISE_BIT = 1;
	localparam int STAT_FRAMING_BIT = 2;
	localparam int STAT_IN_FRAME_BIT = 3;

	localparam logic CTRL_RESET = 1'h0;
	localparam logic [15:0] READ_IDLE = 16'h0000;

	// ********************************************
	// Sample tick phases
	// ********************************************
	localparam logic [4:0] PH_FIRST = 5'h01;
	localparam logic [4:0] PH_TEST_A = 5'h03;
	localparam logic [4:0] PH_TEST_B = 5'h05;
	localparam logic [4:0] PH_TEST_C = 5'h07;
	localparam logic [4:0] PH_SENSE_A = 5'h08;
	localparam logic [4:0] PH_SENSE_B = 5'h09;
	localparam logic [4:0] PH_SENSE_C = 5'h0A;
	localparam logic [4:0] PH_LAST = 5'h10;

	// ********************************************
	// Frame layout
	// ********************************************
	localparam int DATA_BITS_SHORT = 8;
	localparam int DATA_BITS_LONG = 9;
	localparam int SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		ST_HUNT = 2'b00,
		ST_START = 2'b01,
		ST_FRAME = 2'b10
	} fe_state_type;

endpackage : uart_rx_fe_pkg

// File: core/rx_line_sync.sv
// Two-stage synchroniser for the serial input line.
`timescale 1ns/1ps
module rx_line_sync (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_line,
	output logic o_line
);
	logic meta_r;
	logic line_r;

	// Idle line is high, so reset to mark to avoid a false edge
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			meta_r <= 1'b1;
			line_r <= 1'b1;
		end else begin
			meta_r <= i_line;
			line_r <= meta_r;
		end
	end

	assign o_line = line_r;
endmodule : rx_line_sync

// File: core/uart_rx_start_sync_frontend.sv
// Receiver front end: start search, bit timing, majority sense, noise.
`timescale 1ns/1ps
module uart_rx_start_sync_frontend
	import uart_rx_fe_pkg::*;
#(
	parameter int ADDR_W = 2,
	parameter int DATA_W = 16
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_sample_tick,
	input wire logic i_rx_line,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wr_data,
	input wire logic i_wr_stb,
	input wire logic i_rd_stb,
	output logic [DATA_W-1:0] o_rd_data,
	output logic o_bit_stb,
	output logic o_bit_value,
	output logic o_receive_full,
	output logic o_noise_status,
	output logic o_framing_status
);

	// ********************************************
	// State
	// ********************************************
	typedef struct packed {
		fe_state_type state;
		logic [2:0] hist;
		logic [4:0] phase;
		logic [1:0] test;
		logic [1:0] sense;
		logic [3:0] bit_idx;
		logic [8:0] shreg;
		logic noise;
		logic receive_on;
		logic frame_len_sel;
		logic receive_full;
		logic noise_status;
		logic framing_status;
		logic [8:0] rx_data;
		logic [DATA_W-1:0] rd_data;
		logic bit_stb;
		logic bit_value;
	} fe_regs_type;

	fe_regs_type st_r;
	fe_regs_type st_nxt;
	logic rx_s;

	// ********************************************
	// Helpers
	// ********************************************
	function automatic logic maj3(input logic a, input logic b, input logic c);
		maj3 = (a & b) | (a & c) | (b & c);
	endfunction : maj3

	function automatic logic [4:0] next_phase(input logic [4:0] ph);
		next_phase = (ph == PH_LAST) ? PH_FIRST : ph + 5'h01;
	endfunction : next_phase

	function automatic logic [3:0] stop_index(input logic len_sel);
		stop_index = len_sel ? 4'(DATA_BITS_LONG + 1) : 4'(DATA_BITS_SHORT + 1);
	endfunction : stop_index

	rx_line_sync u_sync (
		.i_clk_sys(i_clk_sys),
		.i_rst(i_rst),
		.i_line(i_rx_line),
		.o_line(rx_s)
	);

	// ********************************************
	// Next state
	// ********************************************
	always_comb begin
		logic [4:0] cur;
		logic fall;
		logic level;
		logic disagree;
		logic frame_noise;
		logic [8:0] word;
		cur = 5'h00;
		fall = 1'b0;
		level = 1'b0;
		disagree = 1'b0;
		frame_noise = 1'b0;
		word = 9'h000;
		st_nxt = st_r;
		st_nxt.bit_stb = 1'b0;
		st_nxt.rd_data = READ_IDLE;

		// Register reads; data read clears the receive flags
		if (i_rd_stb) begin
			if (i_addr == ADDR_CONTROL) begin
				st_nxt.rd_data[CTRL_RECEIVE_ON_BIT] = st_r.receive_on;
				st_nxt.rd_data[CTRL_FRAME_LEN_BIT] = st_r.frame_len_sel;
			end else if (i_addr == ADDR_STATUS) begin
				st_nxt.rd_data[STAT_RECEIVE_FULL_BIT] = st_r.receive_full;
				st_nxt.rd_data[STAT_NOISE_BIT] = st_r.noise_status;
				st_nxt.rd_data[STAT_FRAMING_BIT] = st_r.framing_status;
				st_nxt.rd_data[STAT_IN_FRAME_BIT] = (st_r.state != ST_HUNT);
			end else if (i_addr == ADDR_DATA) begin
				st_nxt.rd_data[8:0] = st_r.rx_data;
				st_nxt.receive_full = 1'b0;
				st_nxt.noise_status = 1'b0;
				st_nxt.framing_status = 1'b0;
			end
		end
		if (i_wr_stb && i_addr == ADDR_CONTROL) begin
			st_nxt.receive_on = i_wr_data[CTRL_RECEIVE_ON_BIT];
			st_nxt.frame_len_sel = i_wr_data[CTRL_FRAME_LEN_BIT];
		end

		if (!st_r.receive_on) begin
			// Front end idle and initialised while receive is off
			st_nxt.state = ST_HUNT;
			st_nxt.hist = 3'h0;
			st_nxt.phase = PH_FIRST;
			st_nxt.bit_idx = 4'h0;
			st_nxt.noise = 1'b0;
		end else if (i_sample_tick) begin
			st_nxt.hist = {st_r.hist[1:0], rx_s};
			fall = st_r.hist[0] & ~rx_s;
			case (st_r.state)
				ST_HUNT: begin
					// Line already low, or too few marks: keep waiting
					if (st_r.hist == 3'h7 && !rx_s) begin
						st_nxt.state = ST_START;
						st_nxt.phase = PH_FIRST;
						st_nxt.noise = 1'b0;
						st_nxt.test = 2'h0;
					end
				end
				ST_START: begin
					cur = next_phase(st_r.phase);
					st_nxt.phase = cur;
					if (cur == PH_TEST_A) begin
						st_nxt.test[0] = rx_s;
					end else if (cur == PH_TEST_B) begin
						if (st_r.test[0] && rx_s) begin
							st_nxt.state = ST_HUNT;
						end else begin
							st_nxt.test[1] = rx_s;
						end
					end else if (cur == PH_TEST_C) begin
						if (maj3(st_r.test[0], st_r.test[1], rx_s)) begin
							st_nxt.state = ST_HUNT;
						end else begin
							st_nxt.state = ST_FRAME;
							st_nxt.bit_idx = 4'h0;
							st_nxt.noise = st_r.test[0] | st_r.test[1] | rx_s;
						end
					end
				end
				ST_FRAME: begin
					cur = next_phase(st_r.phase);
					// Resync only outside the sense window so a bit is
					// never sampled twice or skipped
					if (fall && cur > PH_SENSE_C) begin
						cur = PH_FIRST;
					end else if (fall && cur != PH_FIRST && cur < PH_SENSE_A) begin
						cur = PH_FIRST;
						st_nxt.bit_idx = st_r.bit_idx - 4'h1;
					end
					st_nxt.phase = cur;
					if (cur == PH_FIRST) begin
						st_nxt.bit_idx = st_nxt.bit_idx + 4'h1;
					end
					if (cur == PH_SENSE_A) begin
						st_nxt.sense[0] = rx_s;
					end else if (cur == PH_SENSE_B) begin
						st_nxt.sense[1] = rx_s;
					end else if (cur == PH_SENSE_C) begin
						level = maj3(st_r.sense[0], st_r.sense[1], rx_s);
						disagree = ~((st_r.sense[0] == st_r.sense[1]) &&
							(st_r.sense[1] == rx_s));
						frame_noise = st_r.noise | disagree;
						st_nxt.noise = frame_noise;
						st_nxt.bit_stb = 1'b1;
						if (st_r.bit_idx == 4'h0) begin
							st_nxt.bit_value = 1'b0;
						end else begin
							st_nxt.bit_value = level;
						end
						if (st_r.bit_idx == stop_index(st_r.frame_len_sel)) begin
							word = st_r.frame_len_sel ? st_r.shreg :
								{1'b0, st_r.shreg[8:1]};
							// Overrun case leaves all flags untouched
							if (!st_r.receive_full) begin
								st_nxt.rx_data = word;
								st_nxt.receive_full = 1'b1;
								st_nxt.noise_status = frame_noise;
								st_nxt.framing_status = ~level;
							end
							st_nxt.state = ST_HUNT;
						end else if (st_r.bit_idx != 4'h0) begin
							st_nxt.shreg = {level, st_r.shreg[8:1]};
						end
					end
				end
				default: begin
					st_nxt.state = ST_HUNT;
				end
			endcase
		end
	end

	// ********************************************
	// Registers
	// ********************************************
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			st_r <= '0;
			st_r.state <= ST_HUNT;
			st_r.phase <= PH_FIRST;
			st_r.receive_on <= CTRL_RESET;
			st_r.frame_len_sel <= CTRL_RESET;
			st_r.rd_data <= READ_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_rd_data = st_r.rd_data;
	assign o_bit_stb = st_r.bit_stb;
	assign o_bit_value = st_r.bit_value;
	assign o_receive_full = st_r.receive_full;
	assign o_noise_status = st_r.noise_status;
	assign o_framing_status = st_r.framing_status;

endmodule : uart_rx_start_sync_frontend

// File: tb/uart_rx_fe_chk.sv
// Port checker for the receiver front end, with its bind.
`timescale 1ns/1ps
module uart_rx_fe_chk
	import uart_rx_fe_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_sample_tick,
	input wire logic [1:0] i_addr,
	input wire logic i_rd_stb,
	input wire logic [15:0] o_rd_data,
	input wire logic o_bit_stb,
	input wire logic o_receive_full,
	input wire logic o_noise_status,
	input wire logic o_framing_status
);
	// ********
	// Checks
	// ********
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	a_rd_idle: assert property (!$past(i_rd_stb) |-> o_rd_data == 16'h0000)
		else $error("stray read data");
	a_bit_tick: assert property (o_bit_stb |-> $past(i_sample_tick))
		else $error("bit without tick");
	a_bit_gap: assert property (o_bit_stb |=> (!o_bit_stb) [*8])
		else $error("bits too close");
	a_noise_full: assert property (o_noise_status |-> o_receive_full)
		else $error("noise without full");
	a_fe_full: assert property (o_framing_status |-> o_receive_full)
		else $error("framing without full");
	a_full_stop: assert property ($rose(o_receive_full) |-> o_bit_stb)
		else $error("full not at stop");
	a_full_hold: assert property ($fell(o_receive_full) |->
		$past(i_rst) || ($past(i_rd_stb) && $past(i_addr) == ADDR_DATA))
		else $error("full dropped early");
	a_data_clear: assert property ($past(i_rd_stb) &&
		$past(i_addr) == ADDR_DATA && !o_bit_stb |-> !o_receive_full)
		else $error("full kept after read");
endmodule : uart_rx_fe_chk

bind uart_rx_start_sync_frontend uart_rx_fe_chk chk_i (
	.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sample_tick(i_sample_tick),
	.i_addr(i_addr), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
	.o_bit_stb(o_bit_stb), .o_receive_full(o_receive_full),
	.o_noise_status(o_noise_status), .o_framing_status(o_framing_status)
);

// File: tb/serial_sender.sv
// Serial transmitter model driving the receive line on sample ticks.
`timescale 1ns/1ps
module serial_sender (
	input wire logic i_clk_sys,
	input wire logic i_sample_tick,
	output logic o_line
);
	initial o_line = 1'b1;
	task automatic tick_wait();
		do @(posedge i_clk_sys); while (i_sample_tick !== 1'b1);
	endtask : tick_wait
	// Each bit 16 ticks; g flips one tick of bit 0 to fake noise
	task automatic send(input logic [11:0] b, input int n, input int g);
		tick_wait();
		for (int i = 0; i < n; i++) begin
			for (int t = 1; t <= 16; t++) begin
				o_line <= (i == 0 && t == g) ? ~b[i] : b[i];
				tick_wait();
			end
		end
		o_line <= 1'b1;
	endtask : send
endmodule : serial_sender

// File: tb/tb_uart_rx_start_sync_frontend.sv
// Self-checking bench for the receiver front end.
`timescale 1ns/1ps
module tb_uart_rx_start_sync_frontend
	import uart_rx_fe_pkg::*;
;
	logic i_clk_sys = 1'b0, i_rst = 1'b1, i_sample_tick = 1'b0;
	logic i_wr_stb = 1'b0, i_rd_stb = 1'b0, line, o_bit_stb, o_bit_value;
	logic o_receive_full, o_noise_status, o_framing_status;
	logic [1:0] i_addr = 2'h0, tdiv = 2'h0;
	logic [15:0] i_wr_data = 16'h0000, o_rd_data;
	int errors = 0, n_tests = 0;
	logic q[$];
	uart_rx_start_sync_frontend dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
		.i_sample_tick(i_sample_tick), .i_rx_line(line), .i_addr(i_addr),
		.i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
		.o_rd_data(o_rd_data), .o_bit_stb(o_bit_stb),
		.o_bit_value(o_bit_value), .o_receive_full(o_receive_full),
		.o_noise_status(o_noise_status), .o_framing_status(o_framing_status));
	serial_sender tx (.i_clk_sys(i_clk_sys), .i_sample_tick(i_sample_tick),
		.o_line(line));
	always #50 i_clk_sys = ~i_clk_sys;
	// Tick every fourth clock keeps a 10-bit frame near 640 cycles
	always @(posedge i_clk_sys) begin
		tdiv <= tdiv + 2'h1;
		i_sample_tick <= (tdiv == 2'h3);
		if (o_bit_stb === 1'b1) q.push_back(o_bit_value);
	end
	// ********
	// Tasks
	// ********
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [1:0] a, input logic [15:0] d);
		@(posedge i_clk_sys);
		i_addr <= a;
		i_wr_data <= d;
		i_wr_stb <= w;
		i_rd_stb <= !w;
		@(posedge i_clk_sys);
		i_wr_stb <= 1'b0;
		i_rd_stb <= 1'b0;
		#50 if (!w) chk(o_rd_data, d);
	endtask : bus
	// Status FFFF skips the reads, leaving the frame held
	task automatic frame(input logic [11:0] b, input int n, input int g,
		input int nb, input logic [15:0] st, input logic [15:0] dat);
		q.delete();
		tx.send(b, n, g);
		repeat (32) @(posedge i_clk_sys);
		chk(16'(q.size()), 16'(nb));
		foreach (q[i]) chk({15'h0000, q[i]}, {15'h0000, (i == 0) ? 1'b0 : b[i]});
		if (st !== 16'hFFFF) begin
			chk({13'h0000, o_framing_status, o_noise_status, o_receive_full},
				st & 16'h0007);
			bus(1'b0, ADDR_STATUS, st);
			bus(1'b0, ADDR_DATA, dat);
		end
	endtask : frame
	task automatic results();
		if (errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		errors++;
		results();
	end
	initial begin
		repeat (8) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		bus(1'b0, ADDR_CONTROL, 16'h0000);
		bus(1'b0, 2'h3, 16'h0000);
		frame(12'h34A, 10, 0, 0, 16'h0000, 16'h0000);
		bus(1'b1, ADDR_CONTROL, 16'h0001);
		tx.send(12'hFFF, 1, 1);
		frame(12'h34A, 10, 0, 10, 16'h0001, 16'h00A5);
		bus(1'b0, ADDR_STATUS, 16'h0000);
		frame(12'h34A, 10, 3, 10, 16'h0003, 16'h00A5);
		frame(12'h34A, 10, 9, 10, 16'h0003, 16'h00A5);
		frame(12'h14A, 10, 0, 10, 16'h0005, 16'h00A5);
		frame(12'h222, 10, 0, 10, 16'hFFFF, 16'h0000);
		frame(12'h044, 10, 0, 10, 16'h0001, 16'h0011);
		bus(1'b1, ADDR_CONTROL, 16'h0003);
		frame(12'h74A, 11, 0, 11, 16'h0001, 16'h01A5);
		results();
	end
endmodule : tb_uart_rx_start_sync_frontend
